// *** logic/scpr_regs.sv ***
// scpr_regs: system control coprocessor register bank, geometry,
// control, cacheable, bufferable and permission registers
// assumes: one coprocessor transfer per strobe, core clock domain
module scpr_regs (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  // coprocessor transfer
  input  wire logic                      xfer_valid,
  input  wire logic                      xfer_read,
  input  wire logic                      xfer_priv,
  input  wire logic [3:0]                xfer_crn,
  input  wire logic [2:0]                xfer_op2,
  input  wire logic [scpr_pkg::SCPR_W-1:0] xfer_wdata,
  input  wire logic                      vec_high_init,
  output logic      [scpr_pkg::SCPR_W-1:0] xfer_rdata,
  output logic                           xfer_rvalid,
  output logic                           undef_trap,
  // control outputs
  output logic      [31:0]               vector_base,
  output logic                           icache_on,
  output logic                           dcache_on,
  output logic                           protection_on,
  output logic                           big_endian,
  output logic                           async_clock_select,
  output logic                           fastbus_inhibit,
  output scpr_pkg::scpr_clkmode_t        clock_mode,
  // area attributes
  output logic      [7:0]                icache_area,
  output logic      [7:0]                dcache_area,
  output logic      [15:0]               area_write_bufferable,
  output logic      [15:0]               data_area_access,
  output logic      [15:0]               instr_area_access
);
  import scpr_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // storage
  logic [31:0] global_control;
  logic [7:0]  data_area_cacheable;
  logic [7:0]  instr_area_cacheable;
  logic [7:0]  data_area_bufferable;
  logic [15:0] data_area_permissions;
  logic [15:0] instr_area_permissions;
  logic        acc_ok;
  logic        wr;
  logic        rd;
  logic [31:0] next_rdata;

  assign acc_ok = xfer_valid && xfer_priv;
  assign wr     = ce && acc_ok && !xfer_read;
  assign rd     = ce && acc_ok && xfer_read;

  scpr_area_if ai ();
  scpr_area_dec u_dec (
    .a (ai.dec)
  );
  assign ai.dcach   = data_area_cacheable;
  assign ai.icach   = instr_area_cacheable;
  assign ai.dbuf    = data_area_bufferable;
  assign ai.dperm   = data_area_permissions;
  assign ai.iperm   = instr_area_permissions;
  assign ai.prot_on = global_control[SCPR_B_PROT];

  ////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      global_control <= SCPR_CTRL_ONES;
    end else if (ce) begin
      if (wr && xfer_crn == SCPR_CRN_CTRL) begin
        global_control <= xfer_wdata;
      end
    end
  end

  // high vector strap caught one edge after reset release
  logic strap_done;
  logic hivec_strap;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_done  <= 1'b0;
      hivec_strap <= 1'b0;
    end else if (ce && !strap_done) begin
      strap_done  <= 1'b1;
      hivec_strap <= vec_high_init;
    end else if (ce && wr && xfer_crn == SCPR_CRN_CTRL) begin
      hivec_strap <= xfer_wdata[SCPR_B_HIVEC];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // cacheable, bufferable and permission registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_area_cacheable  <= SCPR_AREA_RST;
      instr_area_cacheable <= SCPR_AREA_RST;
    end else if (wr && xfer_crn == SCPR_CRN_CACH) begin
      if (xfer_op2 == SCPR_OP2_DATA) begin
        data_area_cacheable <= xfer_wdata[7:0];
      end else if (xfer_op2 == SCPR_OP2_INST) begin
        instr_area_cacheable <= xfer_wdata[7:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_area_bufferable <= SCPR_AREA_RST;
    end else if (wr && xfer_crn == SCPR_CRN_BUFF && xfer_op2 == SCPR_OP2_DATA) begin
      data_area_bufferable <= xfer_wdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_area_permissions  <= SCPR_PERM_RST;
      instr_area_permissions <= SCPR_PERM_RST;
    end else if (wr && xfer_crn == SCPR_CRN_PERM) begin
      if (xfer_op2 == SCPR_OP2_DATA) begin
        data_area_permissions <= xfer_wdata[15:0];
      end else if (xfer_op2 == SCPR_OP2_INST) begin
        instr_area_permissions <= xfer_wdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux; geometry is a constant so writes cannot alter it
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (xfer_crn)
      SCPR_CRN_GEOM: begin
        if (xfer_op2 == SCPR_OP2_GEOM) begin
          next_rdata = SCPR_GEOM_WORD;
        end
      end
      SCPR_CRN_CTRL: begin
        next_rdata = global_control;
        next_rdata[SCPR_B_HIVEC] = hivec_strap;
      end
      SCPR_CRN_CACH: begin
        if (xfer_op2 == SCPR_OP2_INST) begin
          next_rdata = {24'h00_0000, instr_area_cacheable};
        end else begin
          next_rdata = {24'h00_0000, data_area_cacheable};
        end
      end
      SCPR_CRN_BUFF: begin
        next_rdata = {24'h00_0000, data_area_bufferable};
      end
      SCPR_CRN_PERM: begin
        if (xfer_op2 == SCPR_OP2_INST) begin
          next_rdata = {16'h0000, instr_area_permissions};
        end else begin
          next_rdata = {16'h0000, data_area_permissions};
        end
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xfer_rdata  <= 32'h0000_0000;
      xfer_rvalid <= 1'b0;
      undef_trap  <= 1'b0;
    end else if (ce) begin
      xfer_rvalid <= rd;
      undef_trap  <= xfer_valid && !xfer_priv;
      if (rd) begin
        xfer_rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registered control and area outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vector_base        <= SCPR_VEC_LOW;
      icache_on          <= 1'b0;
      dcache_on          <= 1'b0;
      protection_on      <= 1'b0;
      big_endian         <= 1'b0;
      async_clock_select <= 1'b0;
      fastbus_inhibit    <= 1'b0;
      clock_mode         <= SCPR_CLK_FASTBUS;
    end else if (ce) begin
      vector_base        <= hivec_strap ? SCPR_VEC_HIGH : SCPR_VEC_LOW;
      icache_on          <= global_control[SCPR_B_ICEN];
      dcache_on          <= global_control[SCPR_B_DCEN];
      protection_on      <= global_control[SCPR_B_PROT];
      big_endian         <= global_control[SCPR_B_BIGEND];
      async_clock_select <= global_control[SCPR_B_ASYNC];
      fastbus_inhibit    <= global_control[SCPR_B_NFAST];
      clock_mode <= scpr_clkmode_t'({global_control[SCPR_B_ASYNC],
                                     global_control[SCPR_B_NFAST]});
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      icache_area           <= SCPR_AREA_RST;
      dcache_area           <= SCPR_AREA_RST;
      area_write_bufferable <= SCPR_PERM_RST;
      data_area_access      <= SCPR_PERM_RST;
      instr_area_access     <= SCPR_PERM_RST;
    end else if (ce) begin
      icache_area           <= instr_area_cacheable;
      dcache_area           <= data_area_cacheable;
      area_write_bufferable <= ai.dwb;
      data_area_access      <= ai.dap;
      instr_area_access     <= ai.iap;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // assertions
  AST_GEOM_READ: assert property (@(posedge clk) disable iff (rst)
    rd && xfer_crn == SCPR_CRN_GEOM && xfer_op2 == SCPR_OP2_GEOM
    |=> xfer_rvalid && xfer_rdata == 32'h0f0f_10f1)
    else $error("geometry word wrong");
  AST_GEOM_FIXED: assert property (@(posedge clk) disable iff (rst)
    ce && $past(ce) && xfer_rvalid && $past(xfer_crn) == SCPR_CRN_GEOM
    && $past(xfer_op2) == SCPR_OP2_GEOM |-> xfer_rdata == 32'h0f0f_10f1)
    else $error("geometry changed");
  AST_TRAP: assert property (@(posedge clk) disable iff (rst)
    ce && xfer_valid && !xfer_priv |=> undef_trap && !xfer_rvalid)
    else $error("unprivileged access not trapped");
  AST_ICEN: assert property (@(posedge clk) disable iff (rst)
    ce && wr && xfer_crn == SCPR_CRN_CTRL ##1 ce |=> icache_on == $past(xfer_wdata[12], 2))
    else $error("icache enable wrong");
  AST_PROT: assert property (@(posedge clk) disable iff (rst)
    ce && wr && xfer_crn == SCPR_CRN_CTRL ##1 ce |=> protection_on == $past(xfer_wdata[0], 2))
    else $error("protection enable wrong");
  AST_NOACCESS: assert property (@(posedge clk) disable iff (rst)
    ce && !global_control[SCPR_B_PROT] |=> data_area_access == 16'h0000)
    else $error("access granted with protection off");
  AST_CACH_SEL: assert property (@(posedge clk) disable iff (rst)
    wr && xfer_crn == SCPR_CRN_CACH && xfer_op2 == SCPR_OP2_INST
    |=> $stable(data_area_cacheable) && instr_area_cacheable == $past(xfer_wdata[7:0]))
    else $error("cacheable copy selection wrong");
  AST_PERM_SEL: assert property (@(posedge clk) disable iff (rst)
    wr && xfer_crn == SCPR_CRN_PERM && xfer_op2 == SCPR_OP2_DATA
    |=> $stable(instr_area_permissions) && data_area_permissions == $past(xfer_wdata[15:0]))
    else $error("permission copy selection wrong");
  AST_CLKMODE: assert property (@(posedge clk) disable iff (rst)
    ce |=> clock_mode == scpr_clkmode_t'($past(global_control[31:30])))
    else $error("clock mode wrong");
  AST_CACH_DATA: assert property (@(posedge clk) disable iff (rst)
    wr && xfer_crn == SCPR_CRN_CACH && xfer_op2 == SCPR_OP2_DATA
    |=> $stable(instr_area_cacheable) && data_area_cacheable == $past(xfer_wdata[7:0]))
    else $error("data cacheable copy wrong");
  AST_DCEN: assert property (@(posedge clk) disable iff (rst)
    ce && wr && xfer_crn == SCPR_CRN_CTRL ##1 ce
    |=> dcache_on == $past(xfer_wdata[SCPR_B_DCEN], 2))
    else $error("dcache enable wrong");
  AST_BIGEND: assert property (@(posedge clk) disable iff (rst)
    ce && wr && xfer_crn == SCPR_CRN_CTRL ##1 ce
    |=> big_endian == $past(xfer_wdata[SCPR_B_BIGEND], 2))
    else $error("endianness wrong");
  AST_ASYNC: assert property (@(posedge clk) disable iff (rst)
    ce && wr && xfer_crn == SCPR_CRN_CTRL ##1 ce
    |=> async_clock_select == $past(xfer_wdata[SCPR_B_ASYNC], 2))
    else $error("async clock select wrong");
  AST_NFAST: assert property (@(posedge clk) disable iff (rst)
    ce && wr && xfer_crn == SCPR_CRN_CTRL ##1 ce
    |=> fastbus_inhibit == $past(xfer_wdata[SCPR_B_NFAST], 2))
    else $error("fastbus inhibit wrong");
  AST_HIVEC: assert property (@(posedge clk) disable iff (rst)
    ce && wr && strap_done && xfer_crn == SCPR_CRN_CTRL ##1 ce
    |=> vector_base == ($past(xfer_wdata[SCPR_B_HIVEC], 2) ? SCPR_VEC_HIGH : SCPR_VEC_LOW))
    else $error("vector base wrong");
  AST_STRAP: assert property (@(posedge clk) disable iff (rst)
    ce && !strap_done |=> hivec_strap == $past(vec_high_init))
    else $error("high vector strap not captured");
  AST_DCACH_OUT: assert property (@(posedge clk) disable iff (rst)
    ce |=> dcache_area == $past(data_area_cacheable))
    else $error("data cacheable output wrong");
  AST_ICACH_OUT: assert property (@(posedge clk) disable iff (rst)
    ce |=> icache_area == $past(instr_area_cacheable))
    else $error("instruction cacheable output wrong");
  AST_BUFF_WR: assert property (@(posedge clk) disable iff (rst)
    wr && xfer_crn == SCPR_CRN_BUFF && xfer_op2 == SCPR_OP2_DATA
    |=> data_area_bufferable == $past(xfer_wdata[7:0]))
    else $error("bufferable write wrong");
  AST_UNUSED_READ: assert property (@(posedge clk) disable iff (rst)
    rd && xfer_crn == SCPR_CRN_GEOM && xfer_op2 != SCPR_OP2_GEOM
    |=> xfer_rvalid && xfer_rdata == 32'h0000_0000)
    else $error("register 0 other selector not zero");
  AST_FREEZE: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(global_control) && $stable(data_area_cacheable)
    && $stable(protection_on))
    else $error("state moved with clock enable low");
  // per-area output checks
  for (genvar n = 0; n < SCPR_AREAS; n++) begin : g_area_chk
    AST_WB_POLICY: assert property (@(posedge clk) disable iff (rst)
      ce |=> area_write_bufferable[2*n +: 2]
             == $past({data_area_cacheable[n], data_area_bufferable[n]}))
      else $error("write buffer policy wrong");
    AST_DACCESS: assert property (@(posedge clk) disable iff (rst)
      ce && global_control[SCPR_B_PROT]
      |=> data_area_access[2*n +: 2] == $past(data_area_permissions[2*n +: 2]))
      else $error("data area permission wrong");
    AST_IACCESS: assert property (@(posedge clk) disable iff (rst)
      ce && global_control[SCPR_B_PROT]
      |=> instr_area_access[2*n +: 2] == $past(instr_area_permissions[2*n +: 2]))
      else $error("instruction area permission wrong");
  end

  ////////////////////////////////////////////////////////////////////
  // cover properties
  COV_GEOM: cover property (@(posedge clk) rd && xfer_crn == SCPR_CRN_GEOM);
  COV_PROT_ON: cover property (@(posedge clk) protection_on && data_area_access != 16'h0000);
  COV_TRAP: cover property (@(posedge clk) undef_trap);
  COV_HIVEC: cover property (@(posedge clk) vector_base == SCPR_VEC_HIGH);
  COV_CLK_ASYNC: cover property (@(posedge clk) clock_mode == SCPR_CLK_ASYNC);
endmodule

// *** logic/scpr_pkg.sv ***
// scpr_pkg: constants for the system control coprocessor register bank
// assumes: single core clock, synchronous coprocessor transfer port
package scpr_pkg;
  localparam int unsigned SCPR_W        = 32;
  localparam logic [3:0]  SCPR_CRN_GEOM = 4'h0;
  localparam logic [3:0]  SCPR_CRN_CTRL = 4'h1;
  localparam logic [3:0]  SCPR_CRN_CACH = 4'h2;
  localparam logic [3:0]  SCPR_CRN_BUFF = 4'h3;
  localparam logic [3:0]  SCPR_CRN_RSV4 = 4'h4;
  localparam logic [3:0]  SCPR_CRN_PERM = 4'h5;
  localparam logic [2:0]  SCPR_OP2_DATA = 3'h0;
  localparam logic [2:0]  SCPR_OP2_INST = 3'h1;
  localparam logic [2:0]  SCPR_OP2_GEOM = 3'h1;
  // geometry word fields
  localparam logic [3:0]  SCPR_CTYPE    = 4'h7;
  localparam logic        SCPR_SPLIT    = 1'h1;
  localparam logic [2:0]  SCPR_SIZE     = 3'h3;
  localparam logic [2:0]  SCPR_ASSOC    = 3'h6;
  localparam logic        SCPR_MULT     = 1'h0;
  localparam logic [1:0]  SCPR_LEN      = 2'h1;
  localparam logic [11:0] SCPR_GEOM_HALF = {3'h0, SCPR_SIZE, SCPR_ASSOC, SCPR_MULT, SCPR_LEN};
  localparam logic [31:0] SCPR_GEOM_WORD = {3'h0, SCPR_CTYPE, SCPR_SPLIT,
                                            SCPR_GEOM_HALF, SCPR_GEOM_HALF};
  // control bit positions, reset values, vector bases and encodings
  localparam int unsigned SCPR_B_ASYNC  = 31;
  localparam int unsigned SCPR_B_NFAST  = 30;
  localparam int unsigned SCPR_B_HIVEC  = 13;
  localparam int unsigned SCPR_B_ICEN   = 12;
  localparam int unsigned SCPR_B_BIGEND = 7;
  localparam int unsigned SCPR_B_DCEN   = 2;
  localparam int unsigned SCPR_B_PROT   = 0;
  localparam logic [31:0] SCPR_CTRL_ONES = 32'h0000_0078;
  localparam logic [31:0] SCPR_VEC_LOW  = 32'h0000_0000;
  localparam logic [31:0] SCPR_VEC_HIGH = 32'h0fff_0000;
  localparam int unsigned SCPR_AREAS    = 8;
  localparam logic [7:0]  SCPR_AREA_RST = 8'h00;
  localparam logic [15:0] SCPR_PERM_RST = 16'h0000;
  localparam logic [1:0]  SCPR_AP_NONE  = 2'h0;
  localparam logic [1:0]  SCPR_AP_PRIV  = 2'h1;
  localparam logic [1:0]  SCPR_AP_UREAD = 2'h2;
  localparam logic [1:0]  SCPR_AP_FULL  = 2'h3;
  typedef enum logic [1:0] {
    SCPR_CLK_FASTBUS, SCPR_CLK_SYNC, SCPR_CLK_RSVD, SCPR_CLK_ASYNC
  } scpr_clkmode_t;
  typedef enum logic [1:0] {
    SCPR_WB_UNCACHED_UNBUF, SCPR_WB_UNCACHED_BUF, SCPR_WB_WRITETHROUGH, SCPR_WB_WRITEBACK
  } scpr_wbmode_t;
endpackage

// *** logic/scpr_area_if.sv ***
// scpr_area_if: per-area attribute bundle between bank and decoder
// assumes: scpr_pkg compiled first
interface scpr_area_if;
  logic [7:0]  dcach;
  logic [7:0]  icach;
  logic [7:0]  dbuf;
  logic [15:0] dperm;
  logic [15:0] iperm;
  logic        prot_on;
  logic [15:0] dwb;
  logic [15:0] dap;
  logic [15:0] iap;
  modport bank (output dcach, icach, dbuf, dperm, iperm, prot_on, input dwb, dap, iap);
  modport dec  (input dcach, icach, dbuf, dperm, iperm, prot_on, output dwb, dap, iap);
endinterface

// *** logic/scpr_area_dec.sv ***
// scpr_area_dec: per-area write buffer policy and effective permission
// assumes: driven by scpr_regs through scpr_area_if
module scpr_area_dec (
  scpr_area_if.dec a
);
  import scpr_pkg::*;
  for (genvar n = 0; n < SCPR_AREAS; n++) begin : g_area
    // buffer policy from bufferable and cacheable bits
    assign a.dwb[2*n+1:2*n] = {a.dcach[n], a.dbuf[n]};
    // protection off means every area acts as no access
    assign a.dap[2*n+1:2*n] = a.prot_on ? a.dperm[2*n+1:2*n] : SCPR_AP_NONE;
    assign a.iap[2*n+1:2*n] = a.prot_on ? a.iperm[2*n+1:2*n] : SCPR_AP_NONE;
  end
endmodule

// *** tb/scpr_regs_tb.sv ***
// scpr_regs_tb: self-checking bench for the coprocessor register bank
// assumes: scpr_pkg, scpr_area_if and the logic files are compiled first
module scpr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scpr_pkg::*;
  localparam logic [11:0] HALF = {3'h0, 3'h3, 3'h6, 1'h0, 2'h1};
  localparam logic [7:0]  DCV  = 8'ha5;
  localparam logic [7:0]  BFV  = 8'h0f;
  logic          clk, rst, ce, xfer_valid, xfer_read, xfer_priv, vec_high_init;
  logic [3:0]    xfer_crn;
  logic [2:0]    xfer_op2;
  logic [31:0]   xfer_wdata, xfer_rdata, vector_base, q, w;
  logic          xfer_rvalid, undef_trap, icache_on, dcache_on, protection_on;
  logic          big_endian, async_clock_select, fastbus_inhibit, rv, tr;
  scpr_clkmode_t clock_mode;
  logic [7:0]    icache_area, dcache_area;
  logic [15:0]   area_write_bufferable, data_area_access, instr_area_access;
  int            bad_count, n_checks;

  scpr_regs dut (
    .clk(clk), .rst(rst), .ce(ce),
    .xfer_valid(xfer_valid), .xfer_read(xfer_read), .xfer_priv(xfer_priv),
    .xfer_crn(xfer_crn), .xfer_op2(xfer_op2), .xfer_wdata(xfer_wdata),
    .vec_high_init(vec_high_init), .xfer_rdata(xfer_rdata),
    .xfer_rvalid(xfer_rvalid), .undef_trap(undef_trap),
    .vector_base(vector_base), .icache_on(icache_on), .dcache_on(dcache_on),
    .protection_on(protection_on), .big_endian(big_endian),
    .async_clock_select(async_clock_select), .fastbus_inhibit(fastbus_inhibit),
    .clock_mode(clock_mode), .icache_area(icache_area), .dcache_area(dcache_area),
    .area_write_bufferable(area_write_bufferable),
    .data_area_access(data_area_access), .instr_area_access(instr_area_access)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one transfer, driven at a falling edge, answer sampled a cycle later,
  // then one idle cycle so the strobe never drops and rises in one step
  task automatic xfer(input logic rd, input logic pv, input logic [3:0] crn,
                      input logic [2:0] op2, input logic [31:0] wd);
    xfer_valid = 1'b1;
    xfer_read  = rd;
    xfer_priv  = pv;
    xfer_crn   = crn;
    xfer_op2   = op2;
    xfer_wdata = wd;
    @(negedge clk);
    q  = xfer_rdata;
    rv = xfer_rvalid;
    tr = undef_trap;
    xfer_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic wr(input logic [3:0] crn, input logic [2:0] op2, input logic [31:0] d);
    xfer(1'b0, 1'b1, crn, op2, d);
  endtask

  task automatic rd_chk(input logic [3:0] crn, input logic [2:0] op2, input logic [31:0] e);
    xfer(1'b1, 1'b1, crn, op2, 32'h0);
    chk1(rv, 1'b1);
    chk32(q, e);
  endtask

  task automatic settle;
    repeat (3) @(negedge clk);
  endtask

  task automatic do_reset(input logic strap);
    rst = 1'b1;
    vec_high_init = strap;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #20us;
    bad_count++;
    print_verdict;
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    xfer_valid = 1'b0;
    xfer_read = 1'b0;
    xfer_priv = 1'b1;
    xfer_crn = 4'h0;
    xfer_op2 = 3'h0;
    xfer_wdata = 32'h0;
    vec_high_init = 1'b0;
    bad_count = 0;
    n_checks = 0;
    do_reset(1'b0);
    chk32(vector_base, 32'h0000_0000);
    chk1(big_endian, 1'b0);
    rd_chk(SCPR_CRN_CTRL, SCPR_OP2_DATA, 32'h0000_0078);
    // geometry word and its decoded fields
    rd_chk(SCPR_CRN_GEOM, SCPR_OP2_GEOM, {3'h0, 4'h7, 1'h1, HALF, HALF});
    chk32(32'd512 << q[20:18], 32'd4096);
    chk32(32'd512 << q[8:6], 32'd4096);
    chk32(32'd1 << q[17:15], 32'd64);
    chk32(32'd2 << q[1:0], 32'd4);
    wr(SCPR_CRN_GEOM, SCPR_OP2_GEOM, 32'hffff_ffff);
    rd_chk(SCPR_CRN_GEOM, SCPR_OP2_GEOM, {3'h0, 4'h7, 1'h1, HALF, HALF});
    rd_chk(SCPR_CRN_GEOM, SCPR_OP2_DATA, 32'h0);
    // register 0 with an unused selector reads as zero
    rd_chk(SCPR_CRN_GEOM, 3'h2, 32'h0);
    // control word: every clock mode, bits toggled around it
    for (int i = 0; i < 4; i++) begin
      w = {i[1:0], 16'h0, i[0], i[1], 4'h0, ~i[0], 4'hf, ~i[1], 1'b0, i[0] ^ i[1]};
      wr(SCPR_CRN_CTRL, SCPR_OP2_DATA, w);
      settle;
      rd_chk(SCPR_CRN_CTRL, SCPR_OP2_DATA, w);
      chk32({30'h0, clock_mode}, {30'h0, w[31:30]});
      chk1(async_clock_select, w[31]);
      chk1(fastbus_inhibit, w[30]);
      chk32(vector_base, w[13] ? 32'h0fff_0000 : 32'h0);
      chk1(icache_on, w[12]);
      chk1(dcache_on, w[2]);
      chk1(protection_on, w[0]);
      chk1(big_endian, w[7]);
    end
    // area attributes, five writes in a row, each followed by one idle cycle
    wr(SCPR_CRN_CACH, SCPR_OP2_DATA, {24'h0, DCV});
    wr(SCPR_CRN_CACH, SCPR_OP2_INST, 32'h0000_003c);
    wr(SCPR_CRN_BUFF, SCPR_OP2_DATA, {24'h0, BFV});
    wr(SCPR_CRN_PERM, SCPR_OP2_DATA, 32'h0000_e4b1);
    wr(SCPR_CRN_PERM, SCPR_OP2_INST, 32'h0000_1b4e);
    settle;
    rd_chk(SCPR_CRN_CACH, SCPR_OP2_DATA, {24'h0, DCV});
    rd_chk(SCPR_CRN_CACH, SCPR_OP2_INST, 32'h0000_003c);
    rd_chk(SCPR_CRN_BUFF, SCPR_OP2_DATA, {24'h0, BFV});
    rd_chk(SCPR_CRN_PERM, SCPR_OP2_DATA, 32'h0000_e4b1);
    rd_chk(SCPR_CRN_PERM, SCPR_OP2_INST, 32'h0000_1b4e);
    chk32({24'h0, dcache_area}, {24'h0, DCV});
    chk32({24'h0, icache_area}, 32'h0000_003c);
    for (int n = 0; n < 8; n++) begin
      chk32({30'h0, area_write_bufferable[2*n +: 2]}, {30'h0, DCV[n], BFV[n]});
    end
    chk32({16'h0, data_area_access}, 32'h0);
    chk32({16'h0, instr_area_access}, 32'h0);
    wr(SCPR_CRN_CTRL, SCPR_OP2_DATA, 32'h0000_0079);
    settle;
    chk32({16'h0, data_area_access}, 32'h0000_e4b1);
    chk32({16'h0, instr_area_access}, 32'h0000_1b4e);
    // unprivileged and clock-gated transfers change nothing
    xfer(1'b0, 1'b0, SCPR_CRN_CTRL, SCPR_OP2_DATA, 32'h0000_0078);
    chk1(tr, 1'b1);
    xfer(1'b1, 1'b0, SCPR_CRN_CTRL, SCPR_OP2_DATA, 32'h0);
    chk1(tr, 1'b1);
    chk1(rv, 1'b0);
    ce = 1'b0;
    xfer(1'b0, 1'b1, SCPR_CRN_CTRL, SCPR_OP2_DATA, 32'h0000_0078);
    ce = 1'b1;
    settle;
    chk1(protection_on, 1'b1);
    // second reset with the high-vector strap set
    do_reset(1'b1);
    settle;
    chk32(vector_base, 32'h0fff_0000);
    rd_chk(SCPR_CRN_CTRL, SCPR_OP2_DATA, 32'h0000_2078);
    chk32({24'h0, dcache_area}, 32'h0);
    chk1(protection_on, 1'b0);
    print_verdict;
  end
endmodule
